//--- src/cidrd_caller_match_block.sv
// How it works
// [RULE1] Once the set count of RING lines is reached, the number in the following CLIP line is taken.
// [RULE2] Without wildcard a match needs equal length and equal characters.
// [RULE3] A match while the gate is high sets the match output.
// [RULE4] Gate low holds the output; clear high forces it low.
// [RULE5] With retention on, the output is offered for saving and can be restored after power-down.
// [RULE6] The reference holds at most 28 characters from + , - * and digits.
// [RULE7] The detection ring count is one setting, 1 to 20.
// [RULE8] An asterisk may end the reference or be the whole reference.
// [RULE9] A trailing asterisk needs at least one more caller digit after the prefix.
// [RULE10] A lone asterisk matches any number, plus-asterisk any international number.
// [RULE11] For 15 s after the last RING further calls have no effect.
// [RULE12] Rings counted are RING notifications from the modem.
// [RULE13] Detection never answers the call; nothing is sent to the modem.
// [RULE14] The modem is set up for auto answer by its own ring-count command.
// [RULE15] Equal counts detect at that count; a lower detect count detects first.
// [RULE16] A lower auto-answer count makes detection happen at that count.
// [RULE17] No CLIP line or a broken number means no match and no change.
`timescale 1ns/100ps
module cidrd_caller_match_block
   import cidrd_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC,
   parameter int GUARD_MS    = GUARD_TICKS
) (
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [7:0]  s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   // Modem notification characters (receive only)
   input  wire logic [7:0]  rx_data_i,
   input  wire logic        rx_valid_i,
   // Function block pins
   input  wire logic        gate_i,
   input  wire logic        clear_i,
   input  wire logic        ret_load_i,
   input  wire logic        ret_val_i,
   output logic             match_o,
   output logic             ret_data_o
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, aw_rdy_nxt, w_rdy_nxt;
   logic [7:0]  awaddr_r, awaddr_nxt, wa;
   logic [31:0] wdata_r, wdata_nxt, wd;
   logic [3:0]  wstrb_r, wstrb_nxt, ws;
   logic        bvalid_nxt, rvalid_nxt, ar_rdy_nxt, do_wr, mem_we;
   logic [1:0]  bresp_nxt, rresp_nxt;
   logic [31:0] rdata_nxt;
   logic        ret_en_r, ret_en_nxt;
   logic [4:0]  ring_set_r, ring_set_nxt, aa_set_r, aa_set_nxt, len_r, len_nxt;
   logic        ring_p, start_p, char_p, end_p, num_ok;
   logic [7:0]  num_data, ref_q;
   cidrd_call_t st_r, st_nxt;
   logic [4:0]  cnt_r, cnt_nxt, pos_r, pos_nxt, thr;
   logic        eq_r, eq_nxt, wild_r, wild_nxt, hit, eval, match_nxt;
   logic [31:0] tick_r, tick_nxt;
   logic [15:0] guard_r, guard_nxt;
   logic        tick, expire;

   // ----------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------
   cidrd_parser u_parser ( // RULE13
      .clk_sys_i   (clk_sys_i),
      .rst_n_i     (rst_n_i),
      .rx_data_i   (rx_data_i),
      .rx_valid_i  (rx_valid_i),
      .ring_o      (ring_p),
      .num_start_o (start_p),
      .num_char_o  (char_p),
      .num_end_o   (end_p),
      .num_ok_o    (num_ok),
      .num_data_o  (num_data)
   );

   cidrd_ref_mem #(.DEPTH(REF_MAX), .WIDTH(8), .AW(5)) u_ref (
      .clk_sys_i (clk_sys_i),
      .we_i      (mem_we),
      .waddr_i   (wd[CHAR_IDX +: 5]),
      .wdata_i   (wd[7:0]),
      .raddr_i   (pos_r),
      .rdata_o   (ref_q)
   );

   // ----------------------------------------------------------------
   // AXI4-Lite write path and settings
   // ----------------------------------------------------------------
   // Address and data taken in either order, answered once both held
   always_comb begin
      aw_got_nxt   = aw_got_r || (s_axi_awvalid_i && s_axi_awready_o);
      w_got_nxt    = w_got_r || (s_axi_wvalid_i && s_axi_wready_o);
      awaddr_nxt   = (s_axi_awvalid_i && s_axi_awready_o) ? s_axi_awaddr_i : awaddr_r;
      wdata_nxt    = (s_axi_wvalid_i && s_axi_wready_o) ? s_axi_wdata_i : wdata_r;
      wstrb_nxt    = (s_axi_wvalid_i && s_axi_wready_o) ? s_axi_wstrb_i : wstrb_r;
      wa           = awaddr_nxt;
      wd           = wdata_nxt;
      ws           = wstrb_nxt;
      do_wr        = aw_got_nxt && w_got_nxt && !s_axi_bvalid_o;
      bvalid_nxt   = s_axi_bvalid_o && !s_axi_bready_i;
      bresp_nxt    = s_axi_bresp_o;
      ret_en_nxt   = ret_en_r;
      ring_set_nxt = ring_set_r;
      aa_set_nxt   = aa_set_r;
      len_nxt      = len_r;
      mem_we       = 1'b0;
      if (do_wr) begin
         aw_got_nxt = 1'b0;
         w_got_nxt  = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt  = RESP_OK;
         unique case (wa)
            OFF_CTRL: if (ws[0]) ret_en_nxt = wd[CTRL_RET];
            OFF_RING: begin
               // Out-of-range ring counts are refused
               if (wd[31:5] != '0 || wd[4:0] < RING_MIN || wd[4:0] > RING_MAX) begin // RULE7
                  bresp_nxt = RESP_ERR;
               end else if (ws[0]) begin
                  ring_set_nxt = wd[4:0];
               end
            end
            OFF_AA: begin
               if (wd[31:5] != '0) bresp_nxt = RESP_ERR;
               else if (ws[0]) aa_set_nxt = wd[4:0];
            end
            OFF_LEN: begin
               if (wd[31:5] != '0 || 32'(wd[4:0]) > REF_MAX) bresp_nxt = RESP_ERR; // RULE6
               else if (ws[0]) len_nxt = wd[4:0];
            end
            OFF_CHAR: begin
               // Only the number alphabet may enter the reference
               if (!cidrd_num_ch(wd[7:0]) || 32'(wd[CHAR_IDX +: 5]) >= REF_MAX) begin // RULE6
                  bresp_nxt = RESP_ERR;
               end else begin
                  mem_we = ws[0] && ws[1];
               end
            end
            default: bresp_nxt = RESP_ERR;
         endcase
      end
      aw_rdy_nxt = !aw_got_nxt && !bvalid_nxt;
      w_rdy_nxt  = !w_got_nxt && !bvalid_nxt;
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         aw_got_r        <= 1'b0;
         w_got_r         <= 1'b0;
         awaddr_r        <= '0;
         wdata_r         <= '0;
         wstrb_r         <= '0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o  <= 1'b0;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= RESP_OK;
         ret_en_r        <= 1'b0;
         ring_set_r      <= RING_RST;
         aa_set_r        <= AA_RST;
         len_r           <= LEN_RST;
      end else begin
         aw_got_r        <= aw_got_nxt;
         w_got_r         <= w_got_nxt;
         awaddr_r        <= awaddr_nxt;
         wdata_r         <= wdata_nxt;
         wstrb_r         <= wstrb_nxt;
         s_axi_awready_o <= aw_rdy_nxt;
         s_axi_wready_o  <= w_rdy_nxt;
         s_axi_bvalid_o  <= bvalid_nxt;
         s_axi_bresp_o   <= bresp_nxt;
         ret_en_r        <= ret_en_nxt;
         ring_set_r      <= ring_set_nxt;
         aa_set_r        <= aa_set_nxt;
         len_r           <= len_nxt;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------
   always_comb begin
      rvalid_nxt = s_axi_rvalid_o && !s_axi_rready_i;
      rdata_nxt  = s_axi_rdata_o;
      rresp_nxt  = s_axi_rresp_o;
      if (s_axi_arvalid_i && s_axi_arready_o) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = RESP_OK;
         rdata_nxt  = '0;
         unique case (s_axi_araddr_i)
            OFF_CTRL: rdata_nxt[CTRL_RET] = ret_en_r;
            OFF_RING: rdata_nxt[4:0] = ring_set_r;
            OFF_AA:   rdata_nxt[4:0] = aa_set_r;
            OFF_LEN:  rdata_nxt[4:0] = len_r;
            OFF_CHAR: rdata_nxt = '0;
            OFF_STAT: rdata_nxt = {19'h0, cnt_r, 4'h0, guard_r != '0, st_r, match_o};
            default:  rresp_nxt = RESP_ERR;
         endcase
      end
      ar_rdy_nxt = !rvalid_nxt;
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= '0;
         s_axi_rresp_o   <= RESP_OK;
      end else begin
         s_axi_arready_o <= ar_rdy_nxt;
         s_axi_rvalid_o  <= rvalid_nxt;
         s_axi_rdata_o   <= rdata_nxt;
         s_axi_rresp_o   <= rresp_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Call sequence, comparison, guard time and match output
   // ----------------------------------------------------------------
   // A lower nonzero auto-answer count wins, since the modem stops ringing there
   assign thr  = (aa_set_r != '0 && aa_set_r < ring_set_r) ? aa_set_r : ring_set_r; // RULE15 RULE16
   assign eval = end_p && num_ok && st_r == C_ARMED;
   // Wildcard needs at least one caller digit in the star position
   assign hit  = eq_r && len_r != '0 && (wild_r ? pos_r >= len_r : pos_r == len_r); // RULE2 RULE9
   assign tick   = tick_r == 32'(TICK_CYCLES - 1);
   assign expire = tick && guard_r == 16'h0001 && !ring_p;

   always_comb begin
      st_nxt    = st_r;
      cnt_nxt   = cnt_r;
      pos_nxt   = pos_r;
      eq_nxt    = eq_r;
      wild_nxt  = wild_r;
      tick_nxt  = tick ? '0 : tick_r + 32'h1;
      guard_nxt = guard_r;
      match_nxt = match_o;
      // Only modem RING lines advance the counter; no transmit path exists
      unique case (st_r)
         C_IDLE, C_RING: begin
            if (ring_p) begin // RULE12
               cnt_nxt = (cnt_r == 5'h1f) ? cnt_r : cnt_r + 5'h1;
               st_nxt  = (cnt_nxt >= thr) ? C_ARMED : C_RING; // RULE1
            end
         end
         C_ARMED: if (eval) st_nxt = C_DONE;
         C_DONE:  st_nxt = C_DONE; // RULE11
      endcase
      // Number capture, only for the armed call
      if (st_r == C_ARMED && start_p) begin
         pos_nxt  = '0;
         eq_nxt   = 1'b1;
         wild_nxt = 1'b0;
      end else if (st_r == C_ARMED && char_p) begin
         pos_nxt = (pos_r == 5'h1f) ? pos_r : pos_r + 5'h1;
         if (!cidrd_num_ch(num_data)) begin
            eq_nxt = 1'b0; // RULE17
         end else if (pos_r < len_r) begin
            if (ref_q == CH_STAR && pos_r == len_r - 5'h1) wild_nxt = 1'b1; // RULE8 RULE10
            else if (ref_q != num_data) eq_nxt = 1'b0; // RULE2
         end else if (!wild_r) begin
            eq_nxt = 1'b0; // RULE2
         end
      end
      // Each RING restarts the guard; its end closes the call
      if (ring_p) guard_nxt = 16'(GUARD_MS); // RULE11
      else if (tick && guard_r != '0) guard_nxt = guard_r - 16'h1;
      if (expire) begin
         st_nxt  = C_IDLE;
         cnt_nxt = '0;
      end
      // Clear beats restore beats a fresh hit
      if (clear_i) match_nxt = 1'b0; // RULE4
      else if (ret_load_i) match_nxt = ret_en_r ? ret_val_i : match_o; // RULE5
      else if (eval && hit && gate_i) match_nxt = 1'b1; // RULE3
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         st_r       <= C_IDLE;
         cnt_r      <= '0;
         pos_r      <= '0;
         eq_r       <= 1'b0;
         wild_r     <= 1'b0;
         tick_r     <= '0;
         guard_r    <= '0;
         match_o    <= 1'b0;
         ret_data_o <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         cnt_r      <= cnt_nxt;
         pos_r      <= pos_nxt;
         eq_r       <= eq_nxt;
         wild_r     <= wild_nxt;
         tick_r     <= tick_nxt;
         guard_r    <= guard_nxt;
         match_o    <= match_nxt;
         ret_data_o <= ret_en_r && match_nxt; // RULE5
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   clear_forces_a: assert property (clear_i |=> !match_o) // RULE4
      else $error("match not low after clear");
   gate_hold_a: assert property (!gate_i && !clear_i && !ret_load_i |=> $stable(match_o)) // RULE4
      else $error("match changed while gate low");
   hit_sets_a: assert property (eval && hit && gate_i && !clear_i && !ret_load_i |=> match_o) // RULE3
      else $error("match not set on hit");
   miss_keeps_a: assert property (eval && !hit && !clear_i && !ret_load_i |=> $stable(match_o)) // RULE17
      else $error("miss changed match");
   exact_len_a: assert property (eval && !wild_r && pos_r != len_r && !clear_i && !ret_load_i // RULE2
                                 |=> $stable(match_o))
      else $error("exact hit with wrong length");
   wild_more_a: assert property (eval && wild_r && eq_r && gate_i && !clear_i && !ret_load_i // RULE9
                                 |=> match_o)
      else $error("wildcard prefix hit not set");
   ring_range_a: assert property (ring_set_r >= RING_MIN && ring_set_r <= RING_MAX) // RULE7
      else $error("ring count out of range");
   ref_len_a: assert property (32'(len_r) <= REF_MAX) // RULE6
      else $error("reference too long");
   armed_count_a: assert property (st_r != C_ARMED && $past(st_r) != C_ARMED ##1 st_r == C_ARMED
                                   |-> cnt_r >= thr) // RULE1
      else $error("armed before ring count");
   done_ignores_a: assert property (st_r == C_DONE && ring_p |=> st_r == C_DONE && guard_r != '0) // RULE11
      else $error("ring not ignored in guard time");
   restore_a: assert property (ret_load_i && !clear_i && ret_en_r |=> match_o == $past(ret_val_i)) // RULE5
      else $error("restore failed");

   detect_c: cover property (eval && hit && gate_i);
   wild_c:   cover property (eval && hit && wild_r);
   guard_c:  cover property (st_r == C_DONE ##1 expire);

endmodule

//--- src/cidrd_pkg.sv
package cidrd_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS      = 8;
   localparam int GUARD_S     = 15;
   localparam int TICK_NS     = 1000000;
   localparam int TICK_CYC    = TICK_NS / CLK_NS;
   localparam int GUARD_TICKS = GUARD_S * 1000;

   // ----------------------------------------------------------------
   // Limits and reset values
   // ----------------------------------------------------------------
   localparam int         REF_MAX  = 28;
   localparam logic [4:0] RING_MIN = 5'h01;
   localparam logic [4:0] RING_MAX = 5'h14;
   localparam logic [4:0] RING_RST = 5'h01;
   localparam logic [4:0] AA_RST   = 5'h00;
   localparam logic [4:0] LEN_RST  = 5'h00;

   // ----------------------------------------------------------------
   // Register map (byte addresses) and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_RING = 8'h04;
   localparam logic [7:0] OFF_AA   = 8'h08;
   localparam logic [7:0] OFF_LEN  = 8'h0c;
   localparam logic [7:0] OFF_CHAR = 8'h10;
   localparam logic [7:0] OFF_STAT = 8'h14;
   localparam int         CTRL_RET = 0;
   localparam int         CHAR_IDX = 8;
   localparam logic [1:0] RESP_OK  = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;

   // ----------------------------------------------------------------
   // Characters of the notification stream
   // ----------------------------------------------------------------
   localparam logic [7:0]  CH_0     = 8'h30;
   localparam logic [7:0]  CH_9     = 8'h39;
   localparam logic [7:0]  CH_PLUS  = 8'h2b;
   localparam logic [7:0]  CH_COMMA = 8'h2c;
   localparam logic [7:0]  CH_DASH  = 8'h2d;
   localparam logic [7:0]  CH_STAR  = 8'h2a;
   localparam logic [7:0]  CH_QUOTE = 8'h22;
   localparam logic [7:0]  CH_CR    = 8'h0d;
   localparam logic [7:0]  CH_LF    = 8'h0a;
   localparam logic [31:0] RING_STR = 32'h52494e47;
   localparam logic [63:0] CLIP_STR = 64'h2b434c49503a2022;
   localparam logic [3:0]  RING_LEN = 4'h4;
   localparam logic [3:0]  CLIP_END = 4'h7;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      C_IDLE  = 2'b00,
      C_RING  = 2'b01,
      C_ARMED = 2'b11,
      C_DONE  = 2'b10
   } cidrd_call_t;

   typedef enum logic [1:0] {
      P_HEAD = 2'b00,
      P_NUM  = 2'b01,
      P_SKIP = 2'b11
   } cidrd_prs_t;

   // Character allowed in a phone number
   function automatic logic cidrd_num_ch(input logic [7:0] c);
      return (c >= CH_0 && c <= CH_9) || c == CH_PLUS || c == CH_COMMA ||
             c == CH_DASH || c == CH_STAR;
   endfunction

endpackage

//--- src/cidrd_ref_mem.sv
`timescale 1ns/100ps
module cidrd_ref_mem #(
   parameter int DEPTH = 28,
   parameter int WIDTH = 8,
   parameter int AW    = 5
) (
   // Clock
   input  wire logic             clk_sys_i,
   // Write port
   input  wire logic             we_i,
   input  wire logic [AW-1:0]    waddr_i,
   input  wire logic [WIDTH-1:0] wdata_i,
   // Read port
   input  wire logic [AW-1:0]    raddr_i,
   output logic      [WIDTH-1:0] rdata_o
);

   logic [WIDTH-1:0] mem [DEPTH];

   // Registered read; out-of-range addresses read zero
   always_ff @(posedge clk_sys_i) begin
      if (we_i && 32'(waddr_i) < DEPTH) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= (32'(raddr_i) < DEPTH) ? mem[raddr_i] : '0;
   end

endmodule

//--- src/cidrd_parser.sv
`timescale 1ns/100ps
module cidrd_parser
   import cidrd_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       rst_n_i,
   // Modem character stream
   input  wire logic [7:0] rx_data_i,
   input  wire logic       rx_valid_i,
   // Decoded events
   output logic            ring_o,
   output logic            num_start_o,
   output logic            num_char_o,
   output logic            num_end_o,
   output logic            num_ok_o,
   output logic [7:0]      num_data_o
);

   cidrd_prs_t st_r, st_nxt;
   logic [3:0] idx_r, idx_nxt;
   logic       rok_r, rok_nxt, cok_r, cok_nxt;
   logic       ring_nxt, start_nxt, char_nxt, end_nxt, ok_nxt;
   logic [7:0] dat_nxt;
   logic       eol;

   assign eol = rx_data_i == CH_CR || rx_data_i == CH_LF;

   // ----------------------------------------------------------------
   // Line decoder: RING lines and the quoted number of a CLIP line
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt    = st_r;
      idx_nxt   = idx_r;
      rok_nxt   = rok_r;
      cok_nxt   = cok_r;
      ring_nxt  = 1'b0;
      start_nxt = 1'b0;
      char_nxt  = 1'b0;
      end_nxt   = 1'b0;
      ok_nxt    = num_ok_o;
      dat_nxt   = rx_valid_i ? rx_data_i : num_data_o;
      if (rx_valid_i) begin
         unique case (st_r)
            P_HEAD: begin
               if (eol) begin
                  ring_nxt = rok_r && idx_r == RING_LEN;
                  idx_nxt  = '0;
                  rok_nxt  = 1'b1;
                  cok_nxt  = 1'b1;
               end else begin
                  rok_nxt = rok_r && idx_r < RING_LEN &&
                            rx_data_i == RING_STR[{~idx_r[1:0], 3'b000} +: 8];
                  cok_nxt = cok_r && idx_r <= CLIP_END &&
                            rx_data_i == CLIP_STR[{~idx_r[2:0], 3'b000} +: 8];
                  idx_nxt = (idx_r == 4'hf) ? idx_r : idx_r + 4'h1;
                  if (cok_nxt && idx_r == CLIP_END) begin
                     st_nxt    = P_NUM;
                     start_nxt = 1'b1;
                  end
               end
            end
            P_NUM: begin
               if (rx_data_i == CH_QUOTE) begin
                  end_nxt = 1'b1;
                  ok_nxt  = 1'b1;
                  st_nxt  = P_SKIP;
               end else if (eol) begin
                  // Unterminated number is reported as broken
                  end_nxt = 1'b1;
                  ok_nxt  = 1'b0;
                  st_nxt  = P_HEAD;
                  idx_nxt = '0;
                  rok_nxt = 1'b1;
                  cok_nxt = 1'b1;
               end else begin
                  char_nxt = 1'b1;
               end
            end
            P_SKIP: begin
               if (eol) begin
                  st_nxt  = P_HEAD;
                  idx_nxt = '0;
                  rok_nxt = 1'b1;
                  cok_nxt = 1'b1;
               end
            end
            default: st_nxt = P_HEAD;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         st_r        <= P_HEAD;
         idx_r       <= '0;
         rok_r       <= 1'b1;
         cok_r       <= 1'b1;
         ring_o      <= 1'b0;
         num_start_o <= 1'b0;
         num_char_o  <= 1'b0;
         num_end_o   <= 1'b0;
         num_ok_o    <= 1'b0;
         num_data_o  <= '0;
      end else begin
         st_r        <= st_nxt;
         idx_r       <= idx_nxt;
         rok_r       <= rok_nxt;
         cok_r       <= cok_nxt;
         ring_o      <= ring_nxt;
         num_start_o <= start_nxt;
         num_char_o  <= char_nxt;
         num_end_o   <= end_nxt;
         num_ok_o    <= ok_nxt;
         num_data_o  <= dat_nxt;
      end
   end

endmodule

//--- sim/cidrd_modem.sv
`timescale 1ns/100ps
// Far-side modem: sends notification lines, never answers
module cidrd_modem (
   input  wire logic clk_sys_i,
   output logic [7:0] rx_data_o,
   output logic       rx_valid_o
);
   initial begin
      rx_data_o = 8'h00;
      rx_valid_o = 1'b0;
   end
   // Three cycles a char; stale data inverted, never left standing
   task automatic send(input string s);
      foreach (s[i]) begin
         @(posedge clk_sys_i);
         rx_data_o <= s[i];
         rx_valid_o <= 1'b1;
         @(posedge clk_sys_i);
         rx_data_o <= ~s[i];
         rx_valid_o <= 1'b0;
         @(posedge clk_sys_i);
      end
   endtask
   // Rings then CLIP line; the block applies the lower of detect and a nonzero auto-answer count
   task automatic call(input int rings, input string num);
      repeat (rings) send("RING\r");
      send({"+CLIP: \"", num, "\"\r"});
   endtask
endmodule

//--- sim/caller_id_ring_detect_tb_top.sv
`timescale 1ns/100ps
module caller_id_ring_detect_tb_top import cidrd_pkg::*; ;
   localparam int TK = 20, GM = 5; // Guard must outlast a whole CLIP line
   logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic gate = 1'b1, clr = 1'b0, rld = 1'b0, rval = 1'b0;
   logic [7:0] aw = 8'h00, ar = 8'h00, rxd;
   logic [31:0] wd = 32'h0, rdata;
   logic awr, wrd, bv, arr, rv, rxv, match, rdat;
   logic [1:0] bresp, rresp;
   int err_total = 0, total_checks = 0;
   string d = "0";
   cidrd_caller_match_block #(.TICK_CYCLES(TK), .GUARD_MS(GM)) u_dut (.clk_sys_i(clk), .rst_n_i(rst_n),
      .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
      .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
      .s_axi_rready_i(rry), .rx_data_i(rxd), .rx_valid_i(rxv), .gate_i(gate), .clear_i(clr),
      .ret_load_i(rld), .ret_val_i(rval), .match_o(match), .ret_data_o(rdat));
   cidrd_modem u_modem (.clk_sys_i(clk), .rx_data_o(rxd), .rx_valid_o(rxv));
   // 125 MHz clock
   initial forever #4 clk = ~clk;
   task automatic stop_test();
      if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bounded wait; a hung bus ends the run as a failure
   task automatic tmo(input int n);
      if (n >= 60) begin
         err_total++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
      int n;
      n = 0;
      aw <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
      end while (bv !== 1'b1 && n < 60);
      bry <= 1'b0;
      tmo(n);
      chk(bresp, e);
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      int n;
      n = 0;
      ar <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arr) arv <= 1'b0;
      end while (rv !== 1'b1 && n < 60);
      rry <= 1'b0;
      tmo(n);
      chk({rresp, rdata}, e);
      @(posedge clk);
   endtask
   task automatic setref(input string s);
      wr(OFF_LEN, 32'(s.len()), RESP_OK);
      foreach (s[i]) wr(OFF_CHAR, {19'h0, i[4:0], s[i]}, RESP_OK);
   endtask
   // Clear first so a hit is a fresh rise, then let the guard run out
   task automatic tcall(input int r, input string num, input logic e);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      u_modem.call(r, num);
      chk(match, e);
      repeat (3 * GM * TK) @(posedge clk);
   endtask
   // Main sequence
   initial begin
      void'($urandom(32'hc7b4fce7));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rd(OFF_RING, {RESP_OK, 32'h1});
      rd(OFF_AA, {RESP_OK, 32'h0});
      rd(8'h20, {RESP_ERR, 32'h0});
      wr(OFF_RING, 32'd21, RESP_ERR);
      wr(OFF_LEN, 32'd29, RESP_ERR);
      wr(OFF_CHAR, 32'h41, RESP_ERR);
      wr(OFF_STAT, 32'h0, RESP_ERR);
      wr(OFF_RING, 32'd2, RESP_OK);
      setref("12*");
      d[0] = 8'h30 + 8'($urandom_range(9));
      tcall(1, {"12", d}, 1'b0);
      tcall(2, "12", 1'b0);
      tcall(2, {"12", d, d}, 1'b1);
      tcall(2, {"13", d}, 1'b0);
      setref("+*");
      tcall(2, {"+4", d}, 1'b1);
      tcall(2, {"4", d}, 1'b0);
      setref("*");
      tcall(2, d, 1'b1);
      setref("123");
      tcall(2, "1234", 1'b0);
      tcall(2, "1\r", 1'b0);
      wr(OFF_CTRL, 32'h1, RESP_OK);
      rd(OFF_CTRL, {RESP_OK, 32'h1});
      u_modem.call(2, "123");
      chk({match, rdat}, 2'b11);
      rd(OFF_STAT, {RESP_OK, 32'h20d});
      tcall(2, "123", 1'b0);
      rval <= 1'b1;
      rld <= 1'b1;
      @(posedge clk);
      rld <= 1'b0;
      @(posedge clk);
      chk(match, 1'b1);
      gate <= 1'b0;
      tcall(2, "123", 1'b0);
      gate <= 1'b1;
      wr(OFF_AA, 32'd1, RESP_OK);
      tcall(1, "123", 1'b1);
      stop_test();
   end
endmodule
